/* File: pkg/pwm_mod_pkg.sv */
// Shared constants for the pulse modulator and its main timer
`default_nettype none
package pwm_mod_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] OFS_CTRL2    = 8'hcc;
    localparam logic [7:0] OFS_RELOAD   = 8'hcf;
    localparam logic [7:0] OFS_COUNT    = 8'hcd;
    localparam logic [7:0] OFS_T16_LO   = 8'hea;
    localparam logic [7:0] OFS_T16_HI   = 8'heb;
    localparam logic [7:0] OFS_R16_LO   = 8'hec;
    localparam logic [7:0] OFS_R16_HI   = 8'hed;
    localparam logic [7:0] OFS_CTRL1    = 8'hee;
    // ==========================================================
    // Field positions
    localparam int RUN_BIT              = 0;
    localparam int CLKSEL_BIT           = 1;
    localparam int MODESEL_BIT          = 2;
    localparam int T16_RUN_BIT          = 4;
    localparam int T16_MODE_LSB         = 5;
    localparam logic [2:0] T16_MODE_TOGGLE = 3'h5;
    localparam logic [2:0] T16_MODE_PLAIN  = 3'h4;
    // ==========================================================
    // Reset values and timing
    localparam logic [7:0]  CTRL_RESET   = 8'h00;
    localparam logic [7:0]  RELOAD_RESET = 8'h00;
    localparam logic [15:0] T16_RESET    = 16'h0000;
    localparam int CYCLE_DIVIDE          = 10;
endpackage
`default_nettype wire

/* File: core/cycle_clock_divider.sv */
// Instruction-cycle clock made from the oscillator by division
`timescale 1ns/1ps
`default_nettype none
module cycle_clock_divider #(
    parameter int DIVIDE = pwm_mod_pkg::CYCLE_DIVIDE
) (
    input  wire logic clk,
    input  wire logic srst,
    output logic      cycleLevel,
    output logic      cycleTick
);
    // ==========================================================
    // Checks
    initial begin
        if (DIVIDE < 2 || DIVIDE > 255) begin
            $error("DIVIDE out of range");
        end
    end

    logic [7:0] phase_ff;

    // ==========================================================
    // Divider
    always_ff @(posedge clk) begin
        if (srst) begin
            phase_ff <= 8'h00;
        end else if (phase_ff == 8'(DIVIDE - 1)) begin
            phase_ff <= 8'h00;
        end else begin
            phase_ff <= phase_ff + 8'h01;
        end
    end

    // High for the first half of each cycle
    assign cycleLevel = (phase_ff < 8'(DIVIDE / 2));
    assign cycleTick  = (phase_ff == 8'(DIVIDE - 1));
endmodule
`default_nettype wire

/* File: core/main_timer16.sv */
// Sixteen-bit down timer with auto-reload on underflow
`timescale 1ns/1ps
`default_nettype none
module main_timer16 (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        tick,
    input  wire logic        enable,
    input  wire logic        loadLo,
    input  wire logic        loadHi,
    input  wire logic [7:0]  loadData,
    input  wire logic [15:0] reloadValue,
    output logic [15:0]      count,
    output logic             underflow
);
    logic [15:0] count_ff;

    assign underflow = enable && tick && (count_ff == 16'h0000);
    assign count     = count_ff;

    // ==========================================================
    // Counter, software load wins over counting
    always_ff @(posedge clk) begin
        if (srst) begin
            count_ff <= pwm_mod_pkg::T16_RESET;
        end else if (loadLo) begin
            count_ff <= {count_ff[15:8], loadData};
        end else if (loadHi) begin
            count_ff <= {loadData, count_ff[7:0]};
        end else if (underflow) begin
            count_ff <= reloadValue;
        end else if (enable && tick) begin
            count_ff <= count_ff - 16'h0001;
        end
    end
endmodule
`default_nettype wire

/* File: core/pulse_modulator_pwm_timer.sv */
// Pulse modulator / PWM timer with its register port and main timer
`timescale 1ns/1ps
`default_nettype none
// Function
// - Eight-bit down counter with a software-loaded eight-bit reload register.
// - Modulator clocks from oscillator if clock-select set, else cycle clock.
// - Cycle clock is the oscillator divided by ten.
// - Modulator passes each selected clock pulse to the pin until underflow.
// - Modulator underflow clears run, stops counting, holds pin low.
// - Setting run copies the reload value into the counter and starts it.
// - Clearing run stops the counter at once.
// - Run set, selects clear: free-running half-duty square wave on cycle clock.
// - Square mode toggles the pin each underflow until run clears.
// - Mode clear, clock-select set: variable duty mode, run hardware-owned.
// - Main timer underflow sets run, starts counter, drives pin high.
// - Counter underflow clears run; pin low until next main underflow.
// - Run, clock-select and mode-select clear on reset.
// - Main timer counts at cycle rate and auto-reloads on underflow.
module pulse_modulator_pwm_timer (
    input  wire logic       clk,
    input  wire logic       srst,
    input  wire logic [7:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWrite,
    input  wire logic       regRead,
    output logic [7:0]      regRdata,
    input  wire logic       portData,
    output logic            modulatorOutputPin,
    output logic            timerIoPin
);
    // ==========================================================
    // State and modes
    typedef enum {
        MODE_IDLE,
        MODE_SQUARE,
        MODE_VARIABLE,
        MODE_MOD_CYCLE,
        MODE_MOD_OSC
    } mode_type;

    logic        runBit_ff;
    logic        clkSel_ff;
    logic        modeSel_ff;
    logic [7:0]  reload_ff;
    logic [7:0]  count_ff;
    logic        pin_ff;
    logic        oscPhase_ff;
    logic [7:0]  ctrl1_ff;
    logic [15:0] reload16_ff;
    logic [7:0]  rdata_ff;
    logic        tio_ff;
    logic        cycLevel_ff;

    mode_type    mode;
    logic        cycleLevel;
    logic        cycleTick;
    logic        srcLevel;
    logic        srcTick;
    logic        cycleFall;
    logic        cntUnderflow;
    logic        swRunSet;
    logic        swRunClear;
    logic        ctrlWrite;
    logic        t16Enable;
    logic        t16Underflow;
    logic [15:0] t16Count;
    logic        nxt_pin;

    // ==========================================================
    // Address decode
    function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
        return regWrite && (a == ofs);
    endfunction

    assign ctrlWrite  = hit(regAddr, pwm_mod_pkg::OFS_CTRL2);
    assign swRunSet   = ctrlWrite && regWdata[pwm_mod_pkg::RUN_BIT];
    assign swRunClear = ctrlWrite && !regWdata[pwm_mod_pkg::RUN_BIT];

    // ==========================================================
    // Mode decode
    always_comb begin
        case ({modeSel_ff, clkSel_ff})
            2'b11:   mode = MODE_MOD_OSC;
            2'b10:   mode = MODE_MOD_CYCLE;
            2'b01:   mode = MODE_VARIABLE;
            default: mode = runBit_ff ? MODE_SQUARE : MODE_IDLE;
        endcase
    end

    // ==========================================================
    // Clock sources
    cycle_clock_divider #(
        .DIVIDE     (pwm_mod_pkg::CYCLE_DIVIDE)
    ) u_div (
        .clk        (clk),
        .srst       (srst),
        .cycleLevel (cycleLevel),
        .cycleTick  (cycleTick)
    );

    // Counting at each pulse's end keeps reload+1 pulses for a start mid-cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            cycLevel_ff <= 1'b0;
        end else begin
            cycLevel_ff <= cycleLevel;
        end
    end

    assign cycleFall = cycLevel_ff && !cycleLevel;

    // One oscillator pulse spans two clk edges: high then low
    always_ff @(posedge clk) begin
        if (srst) begin
            oscPhase_ff <= 1'b0;
        end else if (runBit_ff && mode == MODE_MOD_OSC) begin
            oscPhase_ff <= !oscPhase_ff;
        end else begin
            oscPhase_ff <= 1'b0;
        end
    end

    always_comb begin
        if (mode == MODE_MOD_OSC) begin
            srcLevel = !oscPhase_ff;
            srcTick  = oscPhase_ff;
        end else if (mode == MODE_MOD_CYCLE) begin
            srcLevel = cycleLevel;
            srcTick  = cycleFall;
        end else begin
            srcLevel = cycleLevel;
            srcTick  = cycleTick;
        end
    end

    // Underflow is the tick that finds the counter at zero
    assign cntUnderflow = runBit_ff && srcTick && (count_ff == 8'h00);

    // ==========================================================
    // Main timer
    assign t16Enable = ctrl1_ff[pwm_mod_pkg::T16_RUN_BIT]
        && (ctrl1_ff[7:5] == pwm_mod_pkg::T16_MODE_TOGGLE
        || ctrl1_ff[7:5] == pwm_mod_pkg::T16_MODE_PLAIN);

    main_timer16 u_t16 (
        .clk         (clk),
        .srst        (srst),
        .tick        (cycleTick),
        .enable      (t16Enable),
        .loadLo      (hit(regAddr, pwm_mod_pkg::OFS_T16_LO)),
        .loadHi      (hit(regAddr, pwm_mod_pkg::OFS_T16_HI)),
        .loadData    (regWdata),
        .reloadValue (reload16_ff),
        .count       (t16Count),
        .underflow   (t16Underflow)
    );

    always_ff @(posedge clk) begin
        if (srst) begin
            tio_ff <= 1'b0;
        end else if (t16Underflow
            && ctrl1_ff[7:5] == pwm_mod_pkg::T16_MODE_TOGGLE) begin
            tio_ff <= !tio_ff;
        end
    end

    assign timerIoPin = tio_ff;

    // ==========================================================
    // Control register, hardware set/clear against software
    always_ff @(posedge clk) begin
        if (srst) begin
            clkSel_ff  <= 1'b0;
            modeSel_ff <= 1'b0;
        end else if (ctrlWrite) begin
            clkSel_ff  <= regWdata[pwm_mod_pkg::CLKSEL_BIT];
            modeSel_ff <= regWdata[pwm_mod_pkg::MODESEL_BIT];
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            runBit_ff <= 1'b0;
        end else if (mode == MODE_VARIABLE) begin
            // Software has no direct say over run here
            if (t16Underflow) begin
                runBit_ff <= 1'b1;
            end else if (cntUnderflow) begin
                runBit_ff <= 1'b0;
            end
        end else if (swRunSet) begin
            runBit_ff <= 1'b1;
        end else if (swRunClear) begin
            runBit_ff <= 1'b0;
        end else if (cntUnderflow && mode != MODE_SQUARE) begin
            runBit_ff <= 1'b0;
        end
    end

    // ==========================================================
    // Reload and counter
    always_ff @(posedge clk) begin
        if (srst) begin
            reload_ff <= pwm_mod_pkg::RELOAD_RESET;
        end else if (hit(regAddr, pwm_mod_pkg::OFS_RELOAD)) begin
            reload_ff <= regWdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            count_ff <= 8'h00;
        end else if (mode == MODE_VARIABLE && t16Underflow) begin
            count_ff <= reload_ff;
        end else if (mode != MODE_VARIABLE && swRunSet) begin
            count_ff <= reload_ff;
        end else if (!runBit_ff || swRunClear) begin
            count_ff <= count_ff;
        end else if (cntUnderflow && mode == MODE_SQUARE) begin
            count_ff <= reload_ff;
        end else if (srcTick && count_ff != 8'h00) begin
            count_ff <= count_ff - 8'h01;
        end
    end

    // ==========================================================
    // Output pin
    always_comb begin
        nxt_pin = pin_ff;
        case (mode)
            MODE_IDLE: begin
                if (swRunSet) begin
                    nxt_pin = 1'b0;
                end else begin
                    nxt_pin = portData;
                end
            end
            MODE_SQUARE: begin
                if (swRunSet) begin
                    nxt_pin = 1'b0;
                end else if (cntUnderflow) begin
                    nxt_pin = !pin_ff;
                end
            end
            MODE_VARIABLE: begin
                if (t16Underflow) begin
                    nxt_pin = 1'b1;
                end else if (cntUnderflow || !runBit_ff) begin
                    nxt_pin = 1'b0;
                end
            end
            MODE_MOD_CYCLE, MODE_MOD_OSC: begin
                // Pulses only while running; low once stopped
                if (runBit_ff && !cntUnderflow && !swRunClear) begin
                    nxt_pin = srcLevel;
                end else begin
                    nxt_pin = 1'b0;
                end
            end
            default: begin
                nxt_pin = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pin_ff <= 1'b0;
        end else begin
            pin_ff <= nxt_pin;
        end
    end

    // Square mode sees run clear via mode falling to idle
    assign modulatorOutputPin = pin_ff;

    // ==========================================================
    // Main timer control and reload registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ctrl1_ff <= pwm_mod_pkg::CTRL_RESET;
        end else if (hit(regAddr, pwm_mod_pkg::OFS_CTRL1)) begin
            ctrl1_ff <= regWdata;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reload16_ff <= pwm_mod_pkg::T16_RESET;
        end else if (hit(regAddr, pwm_mod_pkg::OFS_R16_LO)) begin
            reload16_ff <= {reload16_ff[15:8], regWdata};
        end else if (hit(regAddr, pwm_mod_pkg::OFS_R16_HI)) begin
            reload16_ff <= {regWdata, reload16_ff[7:0]};
        end
    end

    // ==========================================================
    // Read port, data one cycle after the strobe only
    always_ff @(posedge clk) begin
        if (srst || !regRead) begin
            rdata_ff <= 8'h00;
        end else begin
            case (regAddr)
                pwm_mod_pkg::OFS_CTRL2:  rdata_ff <= {5'h00, modeSel_ff,
                                                      clkSel_ff, runBit_ff};
                pwm_mod_pkg::OFS_RELOAD: rdata_ff <= reload_ff;
                pwm_mod_pkg::OFS_COUNT:  rdata_ff <= count_ff;
                pwm_mod_pkg::OFS_T16_LO: rdata_ff <= t16Count[7:0];
                pwm_mod_pkg::OFS_T16_HI: rdata_ff <= t16Count[15:8];
                pwm_mod_pkg::OFS_R16_LO: rdata_ff <= reload16_ff[7:0];
                pwm_mod_pkg::OFS_R16_HI: rdata_ff <= reload16_ff[15:8];
                pwm_mod_pkg::OFS_CTRL1:  rdata_ff <= ctrl1_ff;
                default:                 rdata_ff <= 8'h00;
            endcase
        end
    end

    assign regRdata = rdata_ff;
endmodule
`default_nettype wire

/* File: bench/pulse_modulator_props.sv */
// Port checker for the pulse modulator
`timescale 1ns/1ps
`default_nettype none
module pulse_modulator_props (
    input wire logic       clk,
    input wire logic       srst,
    input wire logic [7:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic       portData,
    input wire logic       modulatorOutputPin,
    input wire logic       timerIoPin
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // ==========================================
    // Shadows of written setup
    logic [2:0]  ctrlSh_ff;
    logic [7:0]  reloadSh_ff;
    logic [15:0] hiCnt_ff;
    logic [15:0] cfgAge_ff;
    logic        ctlWr;
    logic        rldWr;
    logic [15:0] halfW;
    assign ctlWr = regWrite && regAddr == pwm_mod_pkg::OFS_CTRL2;
    assign rldWr = regWrite && regAddr == pwm_mod_pkg::OFS_RELOAD;
    assign halfW = (16'(reloadSh_ff) + 16'h1) * 16'ha;
    always_ff @(posedge clk) begin
        if (srst) ctrlSh_ff <= 3'h0;
        else if (ctlWr) ctrlSh_ff <= regWdata[2:0];
    end
    always_ff @(posedge clk) begin
        if (srst) reloadSh_ff <= 8'h00;
        else if (rldWr) reloadSh_ff <= regWdata;
    end
    // Age guard: pulses cut by a setup change are not judged
    always_ff @(posedge clk) begin
        if (srst || ctlWr || rldWr) cfgAge_ff <= 16'h0;
        else if (cfgAge_ff != 16'hffff) cfgAge_ff <= cfgAge_ff + 16'h1;
    end
    always_ff @(posedge clk) begin
        if (srst || !modulatorOutputPin) hiCnt_ff <= 16'h0;
        else hiCnt_ff <= hiCnt_ff + 16'h1;
    end
    // ==========================================
    // Properties
    property p_rd_idle;
        !$past(regRead) |-> regRdata == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
    property p_rd_unmapped;
        regRead && regAddr < 8'hc0 |=> regRdata == 8'h00;
    endproperty
    a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
    property p_rd_reload;
        regRead && regAddr == pwm_mod_pkg::OFS_RELOAD |=> regRdata == $past(reloadSh_ff);
    endproperty
    a_rd_reload: assert property (p_rd_reload) else $error("reload readback wrong");
    property p_normal_io;
        $past(ctrlSh_ff, 2) == 3'h0 && $past(ctrlSh_ff) == 3'h0 && ctrlSh_ff == 3'h0
            |-> modulatorOutputPin == $past(portData);
    endproperty
    a_normal_io: assert property (p_normal_io) else $error("pin not port data");
    property p_sq_start_low;
        ctlWr && regWdata[2:0] == 3'h1 |-> ##2 !modulatorOutputPin;
    endproperty
    a_sq_start_low: assert property (p_sq_start_low) else $error("square start not low");
    sequence s_fall_judged;
        $fell(modulatorOutputPin) && cfgAge_ff > hiCnt_ff + 16'h4;
    endsequence
    property p_sq_width;
        s_fall_judged and ctrlSh_ff == 3'h1 |-> hiCnt_ff == halfW;
    endproperty
    a_sq_width: assert property (p_sq_width) else $error("square half period wrong");
    property p_var_width;
        s_fall_judged and ctrlSh_ff[2:1] == 2'b01 |-> hiCnt_ff == halfW;
    endproperty
    a_var_width: assert property (p_var_width) else $error("duty width wrong");
    property p_mod_tc;
        s_fall_judged and ctrlSh_ff[2:1] == 2'b10 |-> hiCnt_ff == 16'h5;
    endproperty
    a_mod_tc: assert property (p_mod_tc) else $error("cycle clock pulse width wrong");
    property p_mod_cki;
        $fell(modulatorOutputPin) && ctrlSh_ff[2:1] == 2'b11 |-> hiCnt_ff == 16'h1;
    endproperty
    a_mod_cki: assert property (p_mod_cki) else $error("oscillator pulse width wrong");
    c_sq: cover property (s_fall_judged and ctrlSh_ff == 3'h1);
    c_var: cover property (s_fall_judged and ctrlSh_ff[2:1] == 2'b01);
    c_cki: cover property ($fell(modulatorOutputPin) && ctrlSh_ff[2:1] == 2'b11);
endmodule
`default_nettype wire

/* File: bench/pwm_load_model.sv */
// Load on the modulator pin: counts and times pulses
`timescale 1ns/1ps
`default_nettype none
module pwm_load_model (
    input  wire logic clk,
    input  wire logic clear,
    input  wire logic pin,
    output var int    rises,
    output var int    lastHigh,
    output var int    lastPeriod
);
    int   hi;
    int   per;
    logic prev;
    // Pin is a driven output; no pull, so any level counts
    always @(posedge clk) begin
        if (clear) begin
            rises <= 0;
            hi <= 0;
            per <= 0;
            prev <= pin;
        end else begin
            prev <= pin;
            per <= per + 1;
            hi <= pin ? hi + 1 : 0;
            if (!pin && prev) lastHigh <= hi;
            if (pin && !prev) begin
                rises <= rises + 1;
                lastPeriod <= per + 1;
                per <= 0;
            end
        end
    end
endmodule
`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the pulse modulator
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("ERROR %s exp %0h got %0h", nm, e, g); end end
module tb_top;
    logic       clk = 1'b0;
    logic       srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    logic [7:0] regWdata = 8'h00;
    logic       regWrite = 1'b0;
    logic       regRead = 1'b0;
    logic [7:0] regRdata;
    logic       portData = 1'b0;
    logic       pin;
    logic       timerIoPin;
    logic       clr = 1'b0;
    int         rises;
    int         lastHigh;
    int         lastPeriod;
    int         mismatches = 0;
    int         tests_run = 0;
    int         cyc = 0;
    logic [7:0] d;
    int         n;
    pulse_modulator_pwm_timer dut (.clk(clk), .srst(srst), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .portData(portData), .modulatorOutputPin(pin), .timerIoPin(timerIoPin));
    pwm_load_model load (.clk(clk), .clear(clr), .pin(pin), .rises(rises),
        .lastHigh(lastHigh), .lastPeriod(lastPeriod));
    initial begin
        forever #2 clk = ~clk;
    end
    // ==========================================
    // Bus and helper tasks
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regWdata <= v;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(negedge clk);
        v = regRdata;
    endtask
    // Start away from the cycle clock high phase so no pulse is cut short
    task automatic start_mod(input logic [7:0] v);
        @(posedge clk) clr <= 1'b1;
        @(posedge clk) clr <= 1'b0;
        while (cyc % 10 != 5) @(posedge clk);
        wr(8'hcc, v);
    endtask
    task automatic final_report;
        if (mismatches == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= srst ? 0 : cyc + 1;
        if (cyc > 20000) begin
            mismatches++;
            final_report();
        end
    end
    // ==========================================
    // Scenarios
    task automatic t_regs;
        rd(8'hcc, d); `CHK("ctrl reset", 8'h00, d)
        rd(8'hcf, d); `CHK("reload reset", 8'h00, d)
        rd(8'h10, d); `CHK("unmapped", 8'h00, d)
        wr(8'hcf, 8'h5a);
        rd(8'hcf, d); `CHK("reload rw", 8'h5a, d)
    endtask
    task automatic t_mod_tc;
        wr(8'hcf, 8'h02);
        repeat (2) begin
            start_mod(8'h05);
            repeat (80) @(posedge clk);
            `CHK("tc pulses", 3, rises)
            rd(8'hcc, d); `CHK("run cleared", 8'h04, d)
            `CHK("pin low", 1'b0, pin)
        end
    endtask
    task automatic t_stop;
        wr(8'hcf, 8'hff);
        start_mod(8'h05);
        repeat (40) @(posedge clk);
        wr(8'hcc, 8'h04);
        repeat (3) @(posedge clk);
        n = rises;
        repeat (50) @(posedge clk);
        `CHK("stopped", n, rises)
    endtask
    task automatic t_cki;
        wr(8'hcf, 8'h03);
        start_mod(8'h07);
        repeat (30) @(posedge clk);
        `CHK("cki pulses", 4, rises)
        `CHK("cki high", 1, lastHigh)
    endtask
    task automatic t_square;
        wr(8'hcf, 8'h01);
        wr(8'hcc, 8'h01);
        repeat (150) @(posedge clk);
        `CHK("sq high", 20, lastHigh)
        `CHK("sq period", 40, lastPeriod)
        wr(8'hcc, 8'h00);
    endtask
    task automatic t_var;
        wr(8'hec, 8'h09);
        wr(8'hed, 8'h00);
        wr(8'hea, 8'h09);
        wr(8'heb, 8'h00);
        wr(8'hcf, 8'h02);
        wr(8'hcc, 8'h02);
        wr(8'hee, 8'hb0);
        repeat (400) @(posedge clk);
        `CHK("var high", 30, lastHigh)
        `CHK("var period", 100, lastPeriod)
        d = {7'h00, timerIoPin};
        repeat (100) @(posedge clk);
        `CHK("tio toggle", !d[0], timerIoPin)
        wr(8'hee, 8'h00);
        // Let a running pulse end, else run stays set and square mode follows
        repeat (40) @(posedge clk);
        wr(8'hcc, 8'h00);
    endtask
    task automatic t_io;
        repeat (3) @(posedge clk);
        portData <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK("io high", 1'b1, pin)
        portData <= 1'b0;
        repeat (3) @(posedge clk);
        `CHK("io low", 1'b0, pin)
    endtask
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        t_regs();
        t_mod_tc();
        t_stop();
        t_cki();
        t_square();
        t_var();
        t_io();
        final_report();
    end
endmodule
bind pulse_modulator_pwm_timer pulse_modulator_props chk (.clk(clk), .srst(srst),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .portData(portData), .modulatorOutputPin(modulatorOutputPin),
    .timerIoPin(timerIoPin));
`default_nettype wire
